// *** rtl/sbs_defs.svh ***
`ifndef SBS_DEFS_SVH
`define SBS_DEFS_SVH

// Register byte offsets on the APB window
`define SBS_ADDR_W            12
`define SBS_OFF_STATUS        12'h000
`define SBS_OFF_MASK          12'h004
`define SBS_OFF_SELECT        12'h008
`define SBS_OFF_CONTROL       12'h00C

// Status bit positions
`define SBS_BIT_TX_OVF        7
`define SBS_BIT_TX_UNF        6
`define SBS_BIT_TX_SLIP       5
`define SBS_BIT_SIG_LOCK      4
`define SBS_BIT_CRC_LOCK      3
`define SBS_BIT_RX_OVF        2
`define SBS_BIT_RX_UNF        1
`define SBS_BIT_RX_SLIP       0

// Event bits cleared by read or by write-one
`define SBS_EVENT_MASK        8'hE7

// Framing select field layout: declare counts
`define SBS_SEL_SIG_LSB       0
`define SBS_SEL_CRC_LSB       4
// Framing control field layout: loss counts and enables
`define SBS_CTL_SIG_LSB       0
`define SBS_CTL_CRC_LSB       4
`define SBS_CTL_SIG_EN        8
`define SBS_CTL_CRC_EN        9
`define SBS_CNT_W             3

// Reset values
`define SBS_RST_STATUS        8'h00
`define SBS_RST_MASK          8'h00
`define SBS_RST_SELECT        8'h22
`define SBS_RST_CONTROL       10'h333

// Slip buffer geometry in bytes: two frames of 32 time slots
`define SBS_FRAME_BYTES       32
`define SBS_BUF_BYTES         64

`endif

// *** rtl/sbs_pkg.sv ***
package sbs_pkg;

  // Multiframe alignment tracker states, Gray ordered
  typedef enum logic [1:0] {
    SBS_HUNT   = 2'b00,
    SBS_LOCKED = 2'b01
  } sbs_lock_state_t;

endpackage : sbs_pkg

// *** rtl/sbs_slip_if.sv ***
`timescale 1ns/1ps

// One slip buffer: access strobes in, slip events and addresses out
interface sbs_slip_if #(parameter int AW = 6);
  logic          wr;
  logic          rd;
  logic [AW-1:0] wr_addr;
  logic [AW-1:0] rd_addr;
  logic          deleted;
  logic          repeated;

  modport ctl (input wr, input rd, output wr_addr, output rd_addr,
               output deleted, output repeated);
  modport user (output wr, output rd, input wr_addr, input rd_addr,
                input deleted, input repeated);
endinterface : sbs_slip_if

// *** rtl/sbs_slip_ctl.sv ***
`timescale 1ns/1ps
`include "sbs_defs.svh"

module sbs_slip_ctl #(
  parameter int AW    = 6,
  parameter int DEPTH = `SBS_BUF_BYTES,
  parameter int FRAME = `SBS_FRAME_BYTES
) (
  input  wire logic clk,
  input  wire logic rst,
  sbs_slip_if.ctl   sb
);

  logic [AW-1:0] wr_ptr_reg, wr_ptr_next;
  logic [AW-1:0] rd_ptr_reg, rd_ptr_next;
  logic [AW:0]   level_reg,  level_next;
  logic          del_reg,    del_next;
  logic          rep_reg,    rep_next;
  logic          full;
  logic          empty;

  assign full  = (level_reg == (AW+1)'(DEPTH));
  assign empty = (level_reg == '0);

  // Pointer and level update with whole-frame slips
  always_comb begin
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    level_next  = level_reg;
    del_next    = 1'b0;
    rep_next    = 1'b0;
    if (sb.wr && full) begin
      rd_ptr_next = rd_ptr_reg + AW'(FRAME);            // Drop oldest frame
      level_next  = level_next - (AW+1)'(FRAME);
      del_next    = 1'b1;
    end
    if (sb.rd && empty) begin
      rd_ptr_next = rd_ptr_reg - AW'(FRAME);            // Replay last frame
      level_next  = level_next + (AW+1)'(FRAME);
      rep_next    = 1'b1;
    end
    if (sb.wr) begin
      wr_ptr_next = wr_ptr_reg + AW'(1);
      level_next  = level_next + (AW+1)'(1);
    end
    if (sb.rd) begin
      rd_ptr_next = rd_ptr_next + AW'(1);
      level_next  = level_next - (AW+1)'(1);
    end
  end

  // State registers
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= AW'(DEPTH - FRAME);                 // Trails writes by the start level
      level_reg  <= (AW+1)'(FRAME);
      del_reg    <= 1'b0;
      rep_reg    <= 1'b0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      level_reg  <= level_next;
      del_reg    <= del_next;
      rep_reg    <= rep_next;
    end
  end

  assign sb.wr_addr  = wr_ptr_reg;
  assign sb.rd_addr  = rd_ptr_reg;
  assign sb.deleted  = del_reg;
  assign sb.repeated = rep_reg;

endmodule : sbs_slip_ctl

// *** rtl/sbs_mf_lock.sv ***
`timescale 1ns/1ps
`include "sbs_defs.svh"

module sbs_mf_lock #(
  parameter int CW = `SBS_CNT_W
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          enable,
  input  wire logic          pat_strobe,
  input  wire logic          pat_ok,
  input  wire logic [CW-1:0] declare_cnt,
  input  wire logic [CW-1:0] loss_cnt,
  output logic               locked
);

  sbs_pkg::sbs_lock_state_t state_reg, state_next;
  logic [CW-1:0]            run_reg,   run_next;

  // Count consecutive good patterns in hunt, bad ones in lock
  always_comb begin
    state_next = state_reg;
    run_next   = run_reg;
    if (!enable) begin
      state_next = sbs_pkg::SBS_HUNT;
      run_next   = '0;
    end else if (pat_strobe) begin
      case (state_reg)
        sbs_pkg::SBS_HUNT: begin
          if (!pat_ok) begin
            run_next = '0;
          end else if (run_reg + CW'(1) >= declare_cnt) begin
            state_next = sbs_pkg::SBS_LOCKED;
            run_next   = '0;
          end else begin
            run_next = run_reg + CW'(1);
          end
        end
        sbs_pkg::SBS_LOCKED: begin
          if (pat_ok) begin
            run_next = '0;
          end else if (run_reg + CW'(1) >= loss_cnt) begin
            state_next = sbs_pkg::SBS_HUNT;
            run_next   = '0;
          end else begin
            run_next = run_reg + CW'(1);
          end
        end
        default: begin
          state_next = sbs_pkg::SBS_HUNT;
          run_next   = '0;
        end
      endcase
    end
  end

  // State registers
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= sbs_pkg::SBS_HUNT;
      run_reg   <= '0;
    end else begin
      state_reg <= state_next;
      run_reg   <= run_next;
    end
  end

  assign locked = (state_reg == sbs_pkg::SBS_LOCKED);

endmodule : sbs_mf_lock

// *** rtl/sbs_status_top.sv ***
// The register offsets and register access over APB were decided locally.
`timescale 1ns/1ps
`include "sbs_defs.svh"

// Notes on behaviour
// - Write into full transmit buffer drops one frame and sets bit 7.
// - Read from empty transmit buffer repeats one frame and sets bit 6.
// - Any transmit frame drop or repeat sets bit 5.
// - Write into full receive buffer drops one frame and sets bit 2.
// - Event bits hold until the register is read or written with ones; either clears them.
// - Bit 4 shows live signalling multiframe lock state.
// - Signalling lock is declared by the selected alignment criterion.
// - Signalling lock is lost after a set count of consecutive bad patterns.
// - Bit 3 shows live CRC multiframe lock, zero while lock is lost.
// - CRC lock declare and loss follow the select and control settings.
// - Lock bits read zero when their alignment function is disabled.
// - Read from empty receive buffer repeats one frame and sets bit 1.
// - Any receive frame drop or repeat sets bit 0.
module sbs_status_top #(
  parameter int AW = 6
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic [`SBS_ADDR_W-1:0] paddr,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   tx_wr,
  input  wire logic                   tx_rd,
  output logic      [AW-1:0]          tx_wr_addr,
  output logic      [AW-1:0]          tx_rd_addr,
  input  wire logic                   rx_wr,
  input  wire logic                   rx_rd,
  output logic      [AW-1:0]          rx_wr_addr,
  output logic      [AW-1:0]          rx_rd_addr,
  input  wire logic                   sig_pat_strobe,
  input  wire logic                   sig_pat_ok,
  input  wire logic                   crc_pat_strobe,
  input  wire logic                   crc_pat_ok,
  output logic                        irq
);

  localparam int CW = `SBS_CNT_W;

  sbs_slip_if #(.AW(AW)) tx_sb ();
  sbs_slip_if #(.AW(AW)) rx_sb ();

  logic [7:0]  status_reg,  status_next;
  logic [7:0]  mask_reg,    mask_next;
  logic [7:0]  select_reg,  select_next;
  logic [9:0]  control_reg, control_next;
  logic [31:0] prdata_reg,  prdata_next;
  logic        err_reg,     err_next;
  logic [7:0]  events;
  logic [7:0]  clr;
  logic [7:0]  live;
  logic        sig_locked;
  logic        crc_locked;
  logic        setup;
  logic        access;
  logic        mapped;

  // Address decode shared by setup and access phases
  function automatic logic is_mapped(input logic [`SBS_ADDR_W-1:0] a);
    return (a == `SBS_OFF_STATUS) || (a == `SBS_OFF_MASK) ||
           (a == `SBS_OFF_SELECT) || (a == `SBS_OFF_CONTROL);
  endfunction : is_mapped

  // Extract a count field from a setting register
  function automatic logic [CW-1:0] field(input logic [9:0] r, input int lsb);
    return CW'(r >> lsb);
  endfunction : field

  // Transmit slip buffer pointer control
  sbs_slip_ctl #(.AW(AW)) u_tx_slip (
    .clk (clk),
    .rst (rst),
    .sb  (tx_sb.ctl)
  );

  // Receive slip buffer pointer control
  sbs_slip_ctl #(.AW(AW)) u_rx_slip (
    .clk (clk),
    .rst (rst),
    .sb  (rx_sb.ctl)
  );

  // Buffer strobes in, addresses out
  assign tx_sb.wr   = tx_wr;
  assign tx_sb.rd   = tx_rd;
  assign rx_sb.wr   = rx_wr;
  assign rx_sb.rd   = rx_rd;
  assign tx_wr_addr = tx_sb.wr_addr;
  assign tx_rd_addr = tx_sb.rd_addr;
  assign rx_wr_addr = rx_sb.wr_addr;
  assign rx_rd_addr = rx_sb.rd_addr;

  // Signalling multiframe tracker
  sbs_mf_lock #(.CW(CW)) u_sig_lock (
    .clk         (clk),
    .rst         (rst),
    .enable      (control_reg[`SBS_CTL_SIG_EN]),
    .pat_strobe  (sig_pat_strobe),
    .pat_ok      (sig_pat_ok),
    .declare_cnt (field({2'b00, select_reg}, `SBS_SEL_SIG_LSB)),
    .loss_cnt    (field(control_reg, `SBS_CTL_SIG_LSB)),
    .locked      (sig_locked)
  );

  // CRC multiframe tracker
  sbs_mf_lock #(.CW(CW)) u_crc_lock (
    .clk         (clk),
    .rst         (rst),
    .enable      (control_reg[`SBS_CTL_CRC_EN]),
    .pat_strobe  (crc_pat_strobe),
    .pat_ok      (crc_pat_ok),
    .declare_cnt (field({2'b00, select_reg}, `SBS_SEL_CRC_LSB)),
    .loss_cnt    (field(control_reg, `SBS_CTL_CRC_LSB)),
    .locked      (crc_locked)
  );

  // Slip events mapped onto status bits
  always_comb begin
    events                    = 8'h00;
    events[`SBS_BIT_TX_OVF]   = tx_sb.deleted;
    events[`SBS_BIT_TX_UNF]   = tx_sb.repeated;
    events[`SBS_BIT_TX_SLIP]  = tx_sb.deleted | tx_sb.repeated;
    events[`SBS_BIT_RX_OVF]   = rx_sb.deleted;
    events[`SBS_BIT_RX_UNF]   = rx_sb.repeated;
    events[`SBS_BIT_RX_SLIP]  = rx_sb.deleted | rx_sb.repeated;
  end

  // Live lock bits
  always_comb begin
    live                     = 8'h00;
    live[`SBS_BIT_SIG_LOCK]  = sig_locked;
    live[`SBS_BIT_CRC_LOCK]  = crc_locked;
  end

  // APB phase decode; zero wait states
  assign setup   = psel && !penable;
  assign access  = psel && penable;
  assign mapped  = is_mapped(paddr);
  assign pready  = 1'b1;

  // Event clears from a completed read or a write of ones
  always_comb begin
    clr = 8'h00;
    if (access && paddr == `SBS_OFF_STATUS) begin
      if (pwrite) begin
        clr = pwdata[7:0] & `SBS_EVENT_MASK;
      end else begin
        clr = `SBS_EVENT_MASK;
      end
    end
  end

  // Sticky event bits; a new event beats a clear
  always_comb begin
    status_next = (status_reg & ~clr) | events;
  end

  // Configuration words, written in the access phase only
  always_comb begin
    mask_next    = mask_reg;
    select_next  = select_reg;
    control_next = control_reg;
    if (access && pwrite) begin
      case (paddr)
        `SBS_OFF_MASK:    mask_next    = pwdata[7:0];
        `SBS_OFF_SELECT:  select_next  = pwdata[7:0];
        `SBS_OFF_CONTROL: control_next = pwdata[9:0];
        default:          mask_next    = mask_reg;
      endcase
    end
  end

  // Read data captured in setup; events merged from the next status
  always_comb begin
    prdata_next = prdata_reg;
    err_next    = err_reg;
    if (setup) begin
      err_next = !mapped;
      case (paddr)
        `SBS_OFF_STATUS:  prdata_next = {24'h000000,
                                         (status_next & `SBS_EVENT_MASK) | live};
        `SBS_OFF_MASK:    prdata_next = {24'h000000, mask_reg};
        `SBS_OFF_SELECT:  prdata_next = {24'h000000, select_reg};
        `SBS_OFF_CONTROL: prdata_next = {22'h000000, control_reg};
        default:          prdata_next = 32'h00000000;
      endcase
      if (pwrite) begin
        prdata_next = 32'h00000000;
      end
    end
  end

  // Event status register
  always_ff @(posedge clk) begin
    if (rst) begin
      status_reg <= `SBS_RST_STATUS;
    end else begin
      status_reg <= status_next;
    end
  end

  // Configuration registers
  always_ff @(posedge clk) begin
    if (rst) begin
      mask_reg    <= `SBS_RST_MASK;
      select_reg  <= `SBS_RST_SELECT;
      control_reg <= `SBS_RST_CONTROL;
    end else begin
      mask_reg    <= mask_next;
      select_reg  <= select_next;
      control_reg <= control_next;
    end
  end

  // Bus answer registers
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata_reg <= 32'h00000000;
      err_reg    <= 1'b0;
    end else begin
      prdata_reg <= prdata_next;
      err_reg    <= err_next;
    end
  end

  assign prdata  = prdata_reg;
  assign pslverr = access && err_reg;

  // Level interrupt from unmasked events
  assign irq = |(status_reg & mask_reg & `SBS_EVENT_MASK);

endmodule : sbs_status_top

// *** test/sbs_status_monitor.sv ***
`timescale 1ns/1ps
`include "sbs_defs.svh"

module sbs_status_monitor #(
  parameter int AW = 6
) (
  input wire logic                   clk,
  input wire logic                   rst,
  input wire logic [`SBS_ADDR_W-1:0] paddr,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire logic                   tx_wr,
  input wire logic [AW-1:0]          tx_wr_addr,
  input wire logic                   rx_wr,
  input wire logic [AW-1:0]          rx_wr_addr,
  input wire logic                   irq
);
  // Decode of the four mapped words
  wire map = paddr == `SBS_OFF_STATUS || paddr == `SBS_OFF_MASK ||
             paddr == `SBS_OFF_SELECT || paddr == `SBS_OFF_CONTROL;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  chk_ready_always: assert property (pready) else $error("pready low");
  chk_err_access: assert property (pslverr |-> psel && penable) else $error("stray pslverr");
  chk_err_unmapped: assert property (psel && penable && !map |-> pslverr)
    else $error("unmapped access without error");
  chk_ok_mapped: assert property (psel && penable && map |-> !pslverr)
    else $error("mapped access flagged");
  chk_rd_unmapped: assert property (psel && !penable && !pwrite && !map |=> prdata == 32'h0)
    else $error("unmapped read not zero");
  chk_rd_write: assert property (psel && !penable && pwrite |=> prdata == 32'h0)
    else $error("read data during write");
  chk_rd_upper: assert property (psel && !penable && !pwrite |=> prdata[31:10] == 22'h0)
    else $error("upper read bits set");
  chk_tx_waddr: assert property (tx_wr |=> tx_wr_addr == $past(tx_wr_addr) + 1'b1)
    else $error("tx write address step");
  chk_tx_whold: assert property (!tx_wr |=> $stable(tx_wr_addr))
    else $error("tx write address moved");
  chk_rx_waddr: assert property (rx_wr |=> rx_wr_addr == $past(rx_wr_addr) + 1'b1)
    else $error("rx write address step");
  chk_irq_reset: assert property (disable iff (1'b0) rst |=> !irq)
    else $error("irq after reset");
endmodule : sbs_status_monitor

bind sbs_status_top sbs_status_monitor #(.AW(AW)) i_sbs_status_monitor (
  .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_wr(tx_wr),
  .tx_wr_addr(tx_wr_addr), .rx_wr(rx_wr), .rx_wr_addr(rx_wr_addr), .irq(irq));

// *** test/slip_buffer_status_register_tb.sv ***
`timescale 1ns/1ps

module slip_buffer_status_register_tb;
  logic        clk, rst, psel, penable, pwrite, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  logic [3:0]  strb, pat;
  logic [7:0]  ev;
  logic [23:0] ad;
  wire  [5:0]  txwa, txra, rxwa, rxra;
  logic [1:0]  lk;
  wire  [31:0] prdata;
  wire         pready, pslverr, irq;
  int          bad_count, compares, nd, nl, v, lvl[2], wp[2], rp[2];

  sbs_status_top i_sbs_status_top (
    .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_wr(strb[3]), .tx_rd(strb[2]), .tx_wr_addr(txwa), .tx_rd_addr(txra),
    .rx_wr(strb[1]), .rx_rd(strb[0]), .rx_wr_addr(rxwa), .rx_rd_addr(rxra),
    .sig_pat_strobe(pat[3]), .sig_pat_ok(pat[2]), .crc_pat_strobe(pat[1]),
    .crc_pat_ok(pat[0]), .irq(irq));

  // Free running clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task close_out;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  task do_reset;
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    lvl[0] = 32;
    lvl[1] = 32;
    wp[0] = 0;
    wp[1] = 0;
    rp[0] = 32;
    rp[1] = 32;
    ev = 8'h00;
    lk = 2'b00;
  endtask : do_reset

  // One APB transfer, waits for pready under a bound
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      bad_count++;
      close_out();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Status read against the model, then model read-clear
  task rdstat;
    apb(12'h000, 1'b0, 32'h0);
    chk(rd, {24'h0, ev | {3'b0, lk[0], lk[1], 3'b0}});
    ad = {6'(wp[0]), 6'(rp[0]), 6'(wp[1]), 6'(rp[1])};
    chk({8'h0, txwa, txra, rxwa, rxra}, {8'h0, ad});
    ev = 8'h00;
  endtask : rdstat

  // One cycle of buffer strobes; full and empty judged on the level before it
  task strobe(input logic [3:0] s);
    bit f, e;
    @(posedge clk);
    strb <= s;
    for (int k = 0; k < 2; k++) begin
      f = s[3-2*k] && lvl[k] == 64;
      e = s[2-2*k] && lvl[k] == 0;
      if (f) begin
        lvl[k] -= 32;
        rp[k] += 32;
        ev |= k ? 8'h05 : 8'hA0;
      end
      if (e) begin
        lvl[k] += 32;
        rp[k] -= 32;
        ev |= k ? 8'h03 : 8'h60;
      end
      if (s[3-2*k]) begin
        lvl[k]++;
        wp[k]++;
      end
      if (s[2-2*k]) begin
        lvl[k]--;
        rp[k]++;
      end
    end
  endtask : strobe

  task burst(input logic [3:0] s, input int n);
    repeat (n) strobe(s);
    strobe(4'h0);
    repeat (3) @(posedge clk);
  endtask : burst

  task pats(input int k, input logic ok, input int n);
    repeat (n) begin
      @(posedge clk);
      pat <= k ? {3'b001, ok} : {1'b1, ok, 2'b00};
    end
    @(posedge clk);
    pat <= 4'h0;
    repeat (2) @(posedge clk);
  endtask : pats

  task chkirq(input logic exp);
    @(posedge clk);
    #1;
    chk(irq, exp);
  endtask : chkirq

  // Main sequence
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, strb, pat, paddr, pwdata} = '0;
    bad_count = 0;
    compares = 0;
    void'($urandom(32'h32F59B60));
    do_reset();
    apb(12'h000, 1'b0, 32'h0);
    chk(rd, 32'h0);
    apb(12'h008, 1'b0, 32'h0);
    chk(rd, 32'h22);
    apb(12'h00C, 1'b0, 32'h0);
    chk(rd, 32'h333);
    apb(12'h010, 1'b0, 32'h0);
    chk(rd, 32'h0);
    chk(er, 32'h1);
    apb(12'h000, 1'b1, 32'hFF);
    rdstat();
    $display("reset and map test done");
    for (int i = 0; i < 4; i++) begin
      do_reset();
      burst(4'h8 >> i, 32);
      rdstat();
      burst(4'h8 >> i, 1);
      rdstat();
      rdstat();
    end
    $display("slip boundary test done");
    do_reset();
    for (int r = 0; r < 4; r++) begin
      repeat (200) begin
        v = (($urandom % 4) < (r % 2 ? 3 : 1)) ? 2 : 1;
        if ($urandom % 8 == 0) begin
          v = 3;
        end
        strobe(4'(v << (($urandom % 2) ? 0 : 2)));
      end
      burst(4'h0, 0);
      rdstat();
    end
    $display("random slip test done");
    do_reset();
    burst(4'h8, 33);
    chkirq(1'b0);
    apb(12'h004, 1'b1, 32'h80);
    chkirq(1'b1);
    apb(12'h004, 1'b0, 32'h0);
    chk(rd, 32'h80);
    apb(12'h000, 1'b1, 32'h80);
    ev &= 8'h7F;
    chkirq(1'b0);
    rdstat();
    $display("interrupt test done");
    for (int k = 0; k < 2; k++) begin
      nd = $urandom % 7 + 1;
      nl = $urandom % 7 + 1;
      apb(12'h008, 1'b1, nd << (4 * k));
      apb(12'h00C, 1'b1, 32'h300 | (nl << (4 * k)));
      pats(k, 1'b1, nd - 1);
      rdstat();
      pats(k, 1'b1, 1);
      lk[k] = 1'b1;
      rdstat();
      pats(k, 1'b0, nl - 1);
      rdstat();
      pats(k, 1'b0, 1);
      lk[k] = 1'b0;
      rdstat();
      pats(k, 1'b1, nd);
      apb(12'h00C, 1'b1, 32'h0);
      rdstat();
    end
    $display("lock test done");
    close_out();
  end
endmodule : slip_buffer_status_register_tb
